// [rtl/mcu_instruction_execute.sv]
/*
 * Execute unit of an 8-bit core. Commands arrive over AXI4-Lite; the unit
 * runs them against its own data memory, program memory port and lookup
 * registers, counting instruction cycles on a clock enable.
 * Assumes program memory answers combinationally on prog_rdata.
 */
`timescale 1ns/1ps

// What this block does
// - Far skips: two cycles, three when skipping
// - Far writes to pc low byte: three cycles
// - Far table reads: three cycles, high byte
// - Increment variants bump lookup pointer first
// - Far zero-skip-move copies byte to work
// - Far inc/dec skip on zero result
// - Far bit test skips on zero/one
// - Far swap to work: two cycles, no flags
// - Add with carry updates five flags
// - Plain add updates five flags
// - Add immediate into work register
// - AND changes only zero flag
// - Call pushes pc plus one, two cycles
// - Byte clear writes zero, no flags
// - Bit clear touches only chosen bit
// - Watchdog clear clears timeout, sleep flags
// - Invert byte, only zero flag
// - Decimal adjust to memory, only carry
// - Decrement, only zero flag
// - Halt stops, clears watchdog and prescaler
// - Halt sets sleep flag, clears timeout
// - Far instructions reach full data range
module mcu_instruction_execute
  import exec_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Program memory read port
  output logic [12:0]      prog_addr,
  input  wire logic [15:0] prog_rdata,
  // Core state
  output logic             clock_gated,
  output logic             busy
);
  import exec_pkg::*;

  // ==========================================================
  // State
  state_type   state_q, state_d;
  cmd_type     cmd_q, cmd_d;
  logic [1:0]  cyc_q, cyc_d, need_q, need_d;
  logic [7:0]  work_register_q, work_register_d;
  logic [7:0]  flags_q, flags_d;
  logic [12:0] pc_q, pc_d, stack_q, stack_d;
  logic [7:0]  lookup_pointer_q, lookup_pointer_d;
  logic [7:0]  lookup_high_byte_q, lookup_high_byte_d;
  logic [4:0]  page_q, page_d;
  logic [15:0] watchdog_timer_q, watchdog_timer_d;
  logic [7:0]  prescale_q, prescale_d;
  logic [7:0]  dmem_q [4096];
  logic        mem_we;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [12:0] paddr_q, paddr_d;

  // Zero test over an eight-bit result
  function automatic logic is_zero(input logic [7:0] v);
    return v == BYTE_ZERO;
  endfunction : is_zero

  // Sum with flags: {zero pad, srange, carry, half, sum}
  function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [4:0] lo;
    logic [7:0] s7;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c};
    s  = {1'b0, a} + {1'b0, b} + {8'h00, c};
    return {1'b0, s7[7] ^ s[8], s[8], lo[4], s[7:0]};
  endfunction : add8

  // ==========================================================
  // Execution
  logic [7:0]  opnd, res;
  logic [11:0] sum;
  logic        skip;
  logic [7:0]  lp_use;

  always_comb begin
    state_d = state_q; cmd_d = cmd_q; cyc_d = cyc_q; need_d = need_q;
    work_register_d = work_register_q; flags_d = flags_q;
    pc_d = pc_q; stack_d = stack_q; page_d = page_q;
    lookup_pointer_d = lookup_pointer_q; lookup_high_byte_d = lookup_high_byte_q;
    watchdog_timer_d = watchdog_timer_q + WDT_ONE;
    prescale_d = prescale_q + PRE_ONE;
    mem_we = 1'b0; mem_addr = cmd_q.addr; mem_wdata = BYTE_ZERO;
    paddr_d = paddr_q;
    opnd = dmem_q[cmd_q.addr];
    res = BYTE_ZERO; sum = 12'h000; skip = 1'b0;
    lp_use = lookup_pointer_q;
    // Plain register writes land once both address and data are held
    if (aw_q && w_q && !bv_q) begin
      if (awa_q == A_WORK) work_register_d = wd_q[7:0];
      if (awa_q == A_LOOKUP) lookup_pointer_d = wd_q[7:0];
      if (awa_q == A_PAGE) page_d = wd_q[4:0];
    end
    case (state_q)
      ST_IDLE: begin
        if (aw_q && w_q && !bv_q && awa_q == A_CMD) begin
          cmd_d = cmd_type'(wd_q[29:0]);
          state_d = (op_type'(wd_q[29:24]) == OP_HALT) ? ST_HALT : ST_EXEC;
          cyc_d = CYC_ONE;
        end
      end
      ST_EXEC: begin
        // Result is committed in the first cycle, table reads in the second; other cycles only count
        if (cyc_q == CYC_ONE) begin
          need_d = CYC_ONE;
          case (op_type'(cmd_q.op))
            OP_ADD, OP_ADC, OP_ADDI: begin
              sum = add8(work_register_q, (op_type'(cmd_q.op) == OP_ADDI) ? cmd_q.lit : opnd,
                         (op_type'(cmd_q.op) == OP_ADC) & flags_q[F_CARRY]);
              res = sum[7:0];
              flags_d[F_CARRY] = sum[9]; flags_d[F_HALF] = sum[8];
              flags_d[F_SRANGE] = sum[10]; flags_d[F_SCARRY] = sum[10] ^ sum[7];
              flags_d[F_ZERO] = is_zero(res);
              if (cmd_q.to_work || op_type'(cmd_q.op) == OP_ADDI) work_register_d = res;
              else begin mem_we = 1'b1; mem_wdata = res; end
            end
            OP_AND, OP_ANDI: begin
              res = work_register_q & ((op_type'(cmd_q.op) == OP_ANDI) ? cmd_q.lit : opnd);
              flags_d[F_ZERO] = is_zero(res);
              if (cmd_q.to_work || op_type'(cmd_q.op) == OP_ANDI) work_register_d = res;
              else begin mem_we = 1'b1; mem_wdata = res; end
            end
            OP_CALL: begin
              stack_d = pc_q + PC_ONE;
              pc_d = {1'b0, cmd_q.addr};
              need_d = CYC_TWO;
            end
            OP_CLR: begin mem_we = 1'b1; mem_wdata = BYTE_ZERO; end
            OP_FCLR: begin mem_we = 1'b1; mem_wdata = BYTE_ZERO; need_d = CYC_TWO; end
            OP_CLRB: begin
              mem_we = 1'b1; mem_wdata = opnd; mem_wdata[cmd_q.bitsel] = 1'b0;
            end
            OP_CLR_WD: begin
              watchdog_timer_d = WDT_ZERO;
              flags_d[F_TIMEOUT] = 1'b0; flags_d[F_SLEEP] = 1'b0;
            end
            OP_INV, OP_DEC: begin
              res = (op_type'(cmd_q.op) == OP_INV) ? ~opnd : opnd - 8'h01;
              flags_d[F_ZERO] = is_zero(res);
              if (cmd_q.to_work) work_register_d = res;
              else begin mem_we = 1'b1; mem_wdata = res; end
            end
            OP_DAA: begin
              res = work_register_q;
              if (res[3:0] > NIBBLE_NINE || flags_q[F_HALF]) res = res + ADJ_LOW;
              if (work_register_q[7:4] > NIBBLE_NINE || flags_q[F_CARRY]) begin
                res = res + ADJ_HIGH;
                flags_d[F_CARRY] = 1'b1;
              end
              mem_we = 1'b1; mem_wdata = res;
            end
            OP_FSZ, OP_FSZA, OP_FSNZ: begin
              skip = is_zero(opnd) ^ (op_type'(cmd_q.op) == OP_FSNZ);
              if (op_type'(cmd_q.op) == OP_FSZA) work_register_d = opnd;
              need_d = skip ? CYC_THREE : CYC_TWO;
            end
            OP_FBZ, OP_FBNZ: begin
              skip = opnd[cmd_q.bitsel] ^ (op_type'(cmd_q.op) == OP_FBZ);
              need_d = skip ? CYC_THREE : CYC_TWO;
            end
            OP_FSIZ, OP_FSDZ: begin
              res = (op_type'(cmd_q.op) == OP_FSIZ) ? opnd + 8'h01 : opnd - 8'h01;
              skip = is_zero(res);
              if (cmd_q.to_work) work_register_d = res;
              else begin mem_we = 1'b1; mem_wdata = res; end
              need_d = skip ? CYC_THREE : CYC_TWO;
            end
            OP_FTAB_PG, OP_FTAB_LAST, OP_FTAB_IPG, OP_FTAB_ILAST: begin
              if (op_type'(cmd_q.op) == OP_FTAB_IPG || op_type'(cmd_q.op) == OP_FTAB_ILAST) begin
                lp_use = lookup_pointer_q + 8'h01;
                lookup_pointer_d = lp_use;
              end
              paddr_d = {(op_type'(cmd_q.op) == OP_FTAB_PG || op_type'(cmd_q.op) == OP_FTAB_IPG)
                         ? page_q : LAST_PAGE, lp_use};
              need_d = CYC_THREE;
            end
            OP_FSWAPA: begin
              work_register_d = {opnd[3:0], opnd[7:4]};
              need_d = CYC_TWO;
            end
            OP_FMOV_PCL: begin
              pc_d = {pc_q[12:8], work_register_q};
              need_d = CYC_THREE;
            end
            default: ;
          endcase
          if (skip) pc_d = pc_q + PC_ONE + PC_ONE;
          else if (op_type'(cmd_q.op) != OP_CALL && op_type'(cmd_q.op) != OP_FMOV_PCL) pc_d = pc_q + PC_ONE;
        end
        // Table word arrives once the address has been presented
        if (cyc_q == CYC_TWO && need_q == CYC_THREE && cmd_q.op >= 6'(OP_FTAB_PG)
            && cmd_q.op <= 6'(OP_FTAB_ILAST)) begin
          lookup_high_byte_d = prog_rdata[15:8];
          mem_we = 1'b1; mem_wdata = prog_rdata[7:0];
        end
        cyc_d = cyc_q + CYC_ONE;
        if (cyc_q != CYC_ONE && cyc_q >= need_q) state_d = ST_IDLE;
        if (cyc_q == CYC_ONE && need_d == CYC_ONE) state_d = ST_IDLE;
      end
      ST_HALT: begin
        watchdog_timer_d = WDT_ZERO; prescale_d = PRE_ZERO;
        flags_d[F_SLEEP] = 1'b1; flags_d[F_TIMEOUT] = 1'b0;
        // A command write wakes the core and runs that command
        if (aw_q && w_q && !bv_q && awa_q == A_CMD) begin
          cmd_d = cmd_type'(wd_q[29:0]);
          state_d = (op_type'(wd_q[29:24]) == OP_HALT) ? ST_HALT : ST_EXEC;
          cyc_d = CYC_ONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE; cmd_q <= '0; cyc_q <= CYC_ONE; need_q <= CYC_ONE;
      work_register_q <= BYTE_ZERO; flags_q <= BYTE_ZERO;
      pc_q <= PC_RESET; stack_q <= PC_RESET; page_q <= '0;
      lookup_pointer_q <= BYTE_ZERO; lookup_high_byte_q <= BYTE_ZERO;
      watchdog_timer_q <= WDT_ZERO; prescale_q <= PRE_ZERO; paddr_q <= PC_RESET;
    end else if (clk_en) begin
      state_q <= state_d; cmd_q <= cmd_d; cyc_q <= cyc_d; need_q <= need_d;
      work_register_q <= work_register_d; flags_q <= flags_d;
      pc_q <= pc_d; stack_q <= stack_d; page_q <= page_d;
      lookup_pointer_q <= lookup_pointer_d; lookup_high_byte_q <= lookup_high_byte_d;
      watchdog_timer_q <= watchdog_timer_d; prescale_q <= prescale_d; paddr_q <= paddr_d;
      if (mem_we) dmem_q[mem_addr] <= mem_wdata;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic cmd_take;
  always_comb begin
    aw_d = aw_q; w_d = w_q; awa_d = awa_q; wd_d = wd_q; bv_d = bv_q; br_d = br_q;
    rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    cmd_take = awa_q == A_CMD && state_q != ST_EXEC;
    if (s_axi_awvalid && !aw_q) begin aw_d = 1'b1; awa_d = s_axi_awaddr; end
    if (s_axi_wvalid && !w_q) begin w_d = 1'b1; wd_d = s_axi_wdata; end
    if (aw_q && w_q && !bv_q && (awa_q != A_CMD || cmd_take)) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
      br_d = (awa_q == A_CMD || awa_q == A_WORK || awa_q == A_LOOKUP || awa_q == A_PAGE) ? RESP_OK : RESP_ERR;
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (s_axi_arvalid && !rv_q) begin
      rv_d = 1'b1; rr_d = RESP_OK;
      case (s_axi_araddr)
        A_WORK:   rd_d = {24'h000000, work_register_q};
        A_STATUS: rd_d = {22'h000000, state_q == ST_HALT, state_q == ST_EXEC, flags_q};
        A_PC:     rd_d = {19'h00000, pc_q};
        A_LOOKUP: rd_d = {16'h0000, lookup_high_byte_q, lookup_pointer_q};
        A_PAGE:   rd_d = {27'h0000000, page_q};
        A_WDT:    rd_d = {16'h0000, watchdog_timer_q};
        default: begin rd_d = 32'h00000000; rr_d = RESP_ERR; end
      endcase
    end
    if (rv_q && s_axi_rready) rv_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h00000000; bv_q <= 1'b0;
      br_q <= RESP_OK; rv_q <= 1'b0; rd_q <= 32'h00000000; rr_q <= RESP_OK;
    end else if (clk_en) begin
      aw_q <= aw_d; w_q <= w_d; awa_q <= awa_d; wd_q <= wd_d; bv_q <= bv_d;
      br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign prog_addr     = paddr_q;
  assign clock_gated   = state_q == ST_HALT;
  assign busy          = state_q == ST_EXEC;

  // ==========================================================
  // Checks
  property p_halt_flags;
    @(posedge aclk) disable iff (!aresetn) (state_q == ST_HALT && clk_en) |=> flags_q[F_SLEEP] && !flags_q[F_TIMEOUT];
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

  property p_skip_len;
    @(posedge aclk) disable iff (!aresetn) (state_q == ST_EXEC && cyc_q == CYC_ONE && clk_en && skip)
      |=> need_q == CYC_THREE;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip length wrong");

  logic   first_cyc;
  op_type cur_op;
  assign first_cyc = state_q == ST_EXEC && cyc_q == CYC_ONE && clk_en;
  assign cur_op    = op_type'(cmd_q.op);

  sequence s_exec_first;
    first_cyc;
  endsequence

  property p_call_len;
    @(posedge aclk) disable iff (!aresetn) (s_exec_first ##0 cur_op == OP_CALL)
      |=> need_q == CYC_TWO && stack_q == $past(pc_q) + PC_ONE;
  endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong");

  property p_table_len;
    @(posedge aclk) disable iff (!aresetn)
      (s_exec_first ##0 (cur_op == OP_FTAB_PG || cur_op == OP_FTAB_LAST || cur_op == OP_FTAB_IPG
                         || cur_op == OP_FTAB_ILAST)) |=> need_q == CYC_THREE;
  endproperty
  a_table_len: assert property (p_table_len) else $error("table read length wrong");

  property p_clr_wd;
    @(posedge aclk) disable iff (!aresetn) (s_exec_first ##0 cur_op == OP_CLR_WD)
      |=> !flags_q[F_SLEEP] && !flags_q[F_TIMEOUT] && watchdog_timer_q == WDT_ZERO;
  endproperty
  a_clr_wd: assert property (p_clr_wd) else $error("watchdog clear wrong");

  property p_swap_flags;
    @(posedge aclk) disable iff (!aresetn) (s_exec_first ##0 cur_op == OP_FSWAPA)
      |=> flags_q == $past(flags_q) && need_q == CYC_TWO;
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");

endmodule : mcu_instruction_execute

// [rtl/exec_pkg.sv]
/*
 * Shared definitions for the instruction execute unit: opcode classes,
 * cycle counts, flag positions, reset values and the AXI4-Lite map.
 * Assumes a single 250 MHz clock domain.
 */
package exec_pkg;

  // ==========================================================
  // Operation classes
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_ADDI, OP_AND, OP_ANDI, OP_CALL, OP_CLR,
    OP_CLRB, OP_CLR_WD, OP_INV, OP_DAA, OP_DEC, OP_HALT,
    OP_FSZ, OP_FSZA, OP_FSNZ, OP_FBZ, OP_FBNZ, OP_FSIZ, OP_FSDZ,
    OP_FTAB_PG, OP_FTAB_LAST, OP_FTAB_IPG, OP_FTAB_ILAST,
    OP_FSWAPA, OP_FCLR, OP_FMOV_PCL
  } op_type;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT} state_type;

  // ==========================================================
  // Command fields, packed together
  typedef struct packed {
    logic [5:0]  op;
    logic        to_work;
    logic [2:0]  bitsel;
    logic [11:0] addr;
    logic [7:0]  lit;
  } cmd_type;

  // ==========================================================
  // Cycle counts
  localparam logic [1:0] CYC_ONE     = 2'h1;
  localparam logic [1:0] CYC_TWO     = 2'h2;
  localparam logic [1:0] CYC_THREE   = 2'h3;

  // ==========================================================
  // Flag positions in the status byte
  localparam int F_CARRY   = 0;
  localparam int F_HALF    = 1;
  localparam int F_ZERO    = 2;
  localparam int F_SRANGE  = 3;
  localparam int F_SLEEP   = 4;
  localparam int F_TIMEOUT = 5;
  localparam int F_SCARRY  = 6;
  localparam int F_CZERO   = 7;

  // ==========================================================
  // Reset values and constants
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  ADJ_LOW     = 8'h06;
  localparam logic [7:0]  ADJ_HIGH    = 8'h60;
  localparam logic [3:0]  NIBBLE_NINE = 4'h9;
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [12:0] PC_ONE      = 13'h0001;
  localparam logic [4:0]  LAST_PAGE   = 5'h1f;
  localparam logic [15:0] WDT_ZERO    = 16'h0000;
  localparam logic [15:0] WDT_ONE     = 16'h0001;
  localparam logic [7:0]  PRE_ZERO    = 8'h00;
  localparam logic [7:0]  PRE_ONE     = 8'h01;

  // ==========================================================
  // AXI4-Lite register map (byte addresses)
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_WORK   = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_PC     = 8'h0c;
  localparam logic [7:0] A_LOOKUP = 8'h10;
  localparam logic [7:0] A_PAGE   = 8'h14;
  localparam logic [7:0] A_WDT    = 8'h18;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

endpackage : exec_pkg

// [testbench/prog_mem_model.sv]
/*
 * Program memory model: answers every address with a fixed word pattern.
 * Assumes the core reads prog_rdata combinationally from prog_addr.
 */
`timescale 1ns/1ps
module prog_mem_model (
  // Program memory port
  input  wire logic [12:0] prog_addr,
  output logic      [15:0] prog_rdata
);
  // ==========================================================
  // Table word pattern, distinct per page and pointer
  assign prog_rdata = {3'h0, prog_addr} ^ 16'ha5c3;
endmodule : prog_mem_model

// [testbench/tb.sv]
/*
 * Self-checking bench for the execute unit, driven over AXI4-Lite.
 * Assumes the work register is writable and far zero-skip-move reads memory.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb;
  import exec_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [7:0]  awa = 8'h00, ara = 8'h00, s0;
  logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [31:0] wd = 32'h0, rdv;
  logic [1:0]  resp;
  logic [3:0]  nb = 4'h0;
  wire logic   awr, wrd, bv, arr, rv, cg, busy;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat;
  wire logic [12:0] pa;
  wire logic [15:0] pd;
  int          n_fail = 0, compares = 0;

  always #2 aclk = ~aclk;
  always @(posedge aclk) if (busy === 1'b1) nb <= nb + 4'h1;

  mcu_instruction_execute dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .prog_addr(pa), .prog_rdata(pd), .clock_gated(cg), .busy(busy));
  prog_mem_model pm (.prog_addr(pa), .prog_rdata(pd));

  // ==========================================================
  // Bus and command tasks
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    brd <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    if (k == 100) begin n_fail++; test_done(); end
    resp = br;
    brd <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    if (k == 100) begin n_fail++; test_done(); end
    rdv = rdat;
    resp = rr;
    rrd <= 1'b0;
  endtask : axr

  // Launch one command, wait for busy to drop, check its cycle count
  task automatic run(input op_type o, input logic tw, input logic [2:0] b, input logic [11:0] ad,
                     input logic [7:0] l, input logic [3:0] cyc);
    int k;
    nb = 4'h0;
    axw(A_CMD, {2'h0, o, tw, b, ad, l});
    for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge aclk);
    if (k == 20) begin n_fail++; test_done(); end
    @(posedge aclk);
    if (cyc !== 4'h0) `CHK(nb, cyc)
  endtask : run

  task automatic peek(input logic [11:0] ad);
    run(OP_FSZA, 1'b1, 3'h0, ad, 8'h00, 4'h0);
    axr(A_WORK);
  endtask : peek

  task automatic poke(input logic [11:0] ad, input logic [7:0] v);
    run(OP_CLR, 1'b0, 3'h0, ad, 8'h00, 4'h0);
    axw(A_WORK, {24'h0, v});
    run(OP_ADD, 1'b0, 3'h0, ad, 8'h00, 4'h0);
  endtask : poke

  // ==========================================================
  // Main sequence
  initial begin
    int i;
    logic [12:0] p0;
    logic [15:0] w;
    op_type so[8] = '{OP_FSZ, OP_FSZ, OP_FSNZ, OP_FBZ, OP_FBNZ, OP_FSIZ, OP_FSDZ, OP_FSDZ};
    logic [7:0] sv[8] = '{8'h00, 8'h05, 8'h05, 8'h04, 8'h04, 8'hff, 8'h02, 8'h01};
    logic [7:0] se[8] = '{8'h00, 8'h05, 8'h05, 8'h04, 8'h04, 8'h00, 8'h01, 8'h01};
    logic [2:0] sb[8] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h0};
    logic       ss[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic       st[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    op_type to[4] = '{OP_FTAB_PG, OP_FTAB_LAST, OP_FTAB_IPG, OP_FTAB_ILAST};
    logic [7:0] tp[4] = '{8'h40, 8'h40, 8'h41, 8'h42};
    logic [7:0] dv[3] = '{8'h12, 8'h3c, 8'ha5};
    logic [7:0] de[3] = '{8'h12, 8'h42, 8'h05};
    logic       dc[3] = '{1'b0, 1'b0, 1'b1};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(A_PC);
    `CHK(rdv[12:0], PC_RESET)
    axr(8'h40);
    `CHK(resp, RESP_ERR)
    `CHK(rdv, 32'h0)
    axw(8'h44, 32'h1);
    `CHK(resp, RESP_ERR)
    // Low and high sectors hold separate bytes
    poke(12'h005, 8'h11);
    poke(12'hf05, 8'h22);
    peek(12'h005);
    `CHK(rdv[7:0], 8'h11)
    peek(12'hf05);
    `CHK(rdv[7:0], 8'h22)
    // Arithmetic and logic flags
    axw(A_WORK, 32'h6f);
    run(OP_ADD, 1'b1, 3'h0, 12'h005, 8'h00, 4'h0);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'h80)
    axr(A_STATUS);
    `CHK(rdv[3:0], 4'ha)
    axw(A_WORK, 32'hff);
    run(OP_ADDI, 1'b1, 3'h0, 12'h000, 8'h01, 4'h0);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'h00)
    axr(A_STATUS);
    `CHK(rdv[3:0], 4'h7)
    axw(A_WORK, 32'h3c);
    run(OP_AND, 1'b0, 3'h0, 12'h005, 8'h00, 4'h0);
    axr(A_STATUS);
    `CHK(rdv[3:0], 4'h3)
    axw(A_WORK, 32'h20);
    run(OP_ADC, 1'b1, 3'h0, 12'h005, 8'h00, 4'h0);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'h31)
    axr(A_STATUS);
    `CHK(rdv[3:0], 4'h0)
    run(OP_INV, 1'b1, 3'h0, 12'h005, 8'h00, 4'h0);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'hef)
    peek(12'h005);
    `CHK(rdv[7:0], 8'h10)
    poke(12'h0a0, 8'h01);
    run(OP_DEC, 1'b0, 3'h0, 12'h0a0, 8'h00, 4'h0);
    axr(A_STATUS);
    `CHK(rdv[F_ZERO], 1'b1)
    run(OP_DEC, 1'b1, 3'h0, 12'h0a0, 8'h00, 4'h0);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'hff)
    axr(A_STATUS);
    s0 = rdv[7:0];
    run(OP_CLR, 1'b0, 3'h0, 12'h0a0, 8'h00, 4'h0);
    axr(A_STATUS);
    `CHK(rdv[7:0], s0)
    poke(12'h0a1, 8'hff);
    run(OP_CLRB, 1'b0, 3'h3, 12'h0a1, 8'h00, 4'h0);
    peek(12'h0a1);
    `CHK(rdv[7:0], 8'hf7)
    // Decimal adjust with carry and half-carry cleared first
    for (i = 0; i < 3; i++) begin
      axw(A_WORK, {24'h0, dv[i]});
      run(OP_ADDI, 1'b1, 3'h0, 12'h000, 8'h00, 4'h0);
      run(OP_DAA, 1'b0, 3'h0, 12'h0b0, 8'h00, 4'h0);
      axr(A_STATUS);
      `CHK(rdv[F_CARRY], dc[i])
      peek(12'h0b0);
      `CHK(rdv[7:0], de[i])
    end
    // Program flow and cycle counts
    run(OP_CALL, 1'b0, 3'h0, 12'h234, 8'h00, 4'h2);
    axr(A_PC);
    `CHK(rdv[12:0], 13'h0234)
    axw(A_WORK, 32'h77);
    run(OP_FMOV_PCL, 1'b0, 3'h0, 12'h000, 8'h00, 4'h3);
    axr(A_PC);
    `CHK(rdv[7:0], 8'h77)
    poke(12'h0c0, 8'h3c);
    run(OP_FSWAPA, 1'b1, 3'h0, 12'h0c0, 8'h00, 4'h2);
    axr(A_WORK);
    `CHK(rdv[7:0], 8'hc3)
    peek(12'h0c0);
    `CHK(rdv[7:0], 8'h3c)
    for (i = 0; i < 8; i++) begin
      poke(12'hd00, sv[i]);
      axr(A_PC);
      p0 = rdv[12:0];
      run(so[i], st[i], sb[i], 12'hd00, 8'h00, ss[i] ? 4'h3 : 4'h2);
      axr(A_PC);
      `CHK(rdv[12:0], p0 + (ss[i] ? 13'h2 : 13'h1))
      peek(12'hd00);
      `CHK(rdv[7:0], se[i])
    end
    // Table reads from given page and last page
    axw(A_PAGE, 32'h03);
    axw(A_LOOKUP, 32'h40);
    for (i = 0; i < 4; i++) begin
      w = {3'h0, (i % 2 == 1) ? LAST_PAGE : 5'h03, tp[i]} ^ 16'ha5c3;
      run(to[i], 1'b0, 3'h0, 12'he00 + i[11:0], 8'h00, 4'h3);
      axr(A_LOOKUP);
      `CHK(rdv[15:0], {w[15:8], tp[i]})
      peek(12'he00 + i[11:0]);
      `CHK(rdv[7:0], w[7:0])
    end
    // Halt and watchdog clear
    run(OP_HALT, 1'b0, 3'h0, 12'h000, 8'h00, 4'h0);
    `CHK(cg, 1'b1)
    axr(A_STATUS);
    `CHK(rdv[F_SLEEP], 1'b1)
    `CHK(rdv[F_TIMEOUT], 1'b0)
    axr(A_WDT);
    `CHK(rdv[15:0], WDT_ZERO)
    run(OP_CLR_WD, 1'b0, 3'h0, 12'h000, 8'h00, 4'h0);
    `CHK(cg, 1'b0)
    axr(A_STATUS);
    `CHK(rdv[F_SLEEP], 1'b0)
    `CHK(rdv[F_TIMEOUT], 1'b0)
    test_done();
  end
endmodule : tb
